// file: rtl/cpms_mode_select.sv
`timescale 1ns/100ps
`default_nettype none

module cpms_mode_select
  import cpms_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire cpms_straps_s straps_i,
  input wire logic [CPMS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [CPMS_DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [CPMS_DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic ext_mode_o,
  output cpms_set_s settings_o,
  output cpms_ser_s serial_o
);

  function automatic logic ext_mode(input cpms_straps_s s);
    logic aux_ok;
    // A low auxiliary pin is taken as a request for strap control.
    aux_ok = (s.aux_mode != CPMS_LVL_LOW);
    if (s.ctl_mode == CPMS_LVL_HIGH)
    begin
      ext_mode = 1'b0;
    end
    else
    begin
      ext_mode = aux_ok && ((s.ctl_mode == CPMS_LVL_LOW) ||
        (s.input_full_scale_level == CPMS_LVL_FLOAT));
    end
  endfunction

  // A floating strap with no defined meaning keeps the last setting.
  function automatic logic lvl_bit(input cpms_lvl_e l, input logic keep);
    unique case (l)
      CPMS_LVL_LOW: lvl_bit = 1'b0;
      CPMS_LVL_HIGH: lvl_bit = 1'b1;
      default: lvl_bit = keep;
    endcase
  endfunction

  // Status image: written mask, all-written flag, mode and live settings.
  function automatic logic [CPMS_DATA_W-1:0] status_word(
    input logic [CPMS_NUM_LOC-1:0] mask,
    input logic ext_on,
    input cpms_set_s cur
  );
    logic [CPMS_DATA_W-1:0] w;
    w = '0;
    w[CPMS_S_MASK +: CPMS_NUM_LOC] = mask;
    w[CPMS_S_ALL] = &mask;
    w[CPMS_S_EXT] = ext_on;
    w[CPMS_S_SET +: $bits(cpms_set_s)] = cur;
    status_word = w;
  endfunction

  logic ext_q;
  logic ext_d;
  cpms_set_s set_q;
  logic rd_go;
  cpms_ser_s ser_q;
  logic wait_q;
  logic [CPMS_DATA_W-1:0] rdata_q;
  logic [CPMS_LOC_W-1:0] loc_q [CPMS_NUM_LOC];
  logic [CPMS_NUM_LOC-1:0] written_q;
  logic [CPMS_NUM_LOC-1:0] hit;
  logic status_hit;
  logic wr_go;

  assign ext_d = ext_mode(straps_i);
  // Only the low byte lane carries a location; other writes are dropped.
  assign wr_go = avs_write_i && !wait_q && avs_byteenable_i[0];
  assign rd_go = avs_read_i && wait_q;
  assign status_hit = (avs_address_i == CPMS_STATUS_OFS);

  genvar g;
  generate
    for (g = 0; g < CPMS_NUM_LOC; g++)
    begin : g_loc
      // Locations sit a word apart so a word-wide master reaches each one.
      assign hit[g] = (avs_address_i ==
        CPMS_LOC_BASE + CPMS_ADDR_W'(CPMS_LOC_STEP * g));

      always_ff @(posedge mclk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          loc_q[g] <= CPMS_LOC_RST;
        end
        else if (wr_go && hit[g])
        begin
          loc_q[g] <= avs_writedata_i[CPMS_LOC_W-1:0];
        end
      end

      // A write marks a location written even under strap control; strap control clears the mark on the next edge without a write.
      always_ff @(posedge mclk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          written_q[g] <= 1'b0;
        end
        else if (wr_go && hit[g])
        begin
          written_q[g] <= 1'b1;
        end
        else if (!ext_q)
        begin
          written_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Each setting has its own register so a floating strap holds only it.
  // Output swing: reduced when low, normal when high.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      set_q.swing_normal <= CPMS_SET_RST.swing_normal;
    end
    else if (ext_d)
    begin
      set_q.swing_normal <= loc_q[0][CPMS_F_SWING];
    end
    else
    begin
      set_q.swing_normal <= lvl_bit(straps_i.output_swing_level,
        set_q.swing_normal);
    end
  end

  // Output edge: negative when low, positive when high.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      set_q.edge_pos <= CPMS_SET_RST.edge_pos;
    end
    else if (ext_d)
    begin
      set_q.edge_pos <= loc_q[0][CPMS_F_EDGE];
    end
    else
    begin
      set_q.edge_pos <= lvl_bit(straps_i.output_edge_select,
        set_q.edge_pos);
    end
  end

  // Double data rate: under strap control only a floating edge strap selects it; in serial control location 0 selects it.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      set_q.ddr <= CPMS_SET_RST.ddr;
    end
    else if (ext_d)
    begin
      set_q.ddr <= loc_q[0][CPMS_F_DDR];
    end
    else
    begin
      set_q.ddr <= (straps_i.output_edge_select == CPMS_LVL_FLOAT);
    end
  end

  // Calibration delay: short when low, long when high.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      set_q.cal_long <= CPMS_SET_RST.cal_long;
    end
    else if (ext_d)
    begin
      set_q.cal_long <= loc_q[0][CPMS_F_CAL];
    end
    else
    begin
      set_q.cal_long <= lvl_bit(straps_i.calibration_delay_select,
        set_q.cal_long);
    end
  end

  // Full-scale range: reduced when low, normal when high.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      set_q.fs_normal <= CPMS_SET_RST.fs_normal;
    end
    else if (ext_d)
    begin
      set_q.fs_normal <= loc_q[0][CPMS_F_FS];
    end
    else
    begin
      set_q.fs_normal <= lvl_bit(straps_i.input_full_scale_level,
        set_q.fs_normal);
    end
  end

  // Mode follows the straps on every edge; nothing is latched at start-up.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ext_q <= 1'b0;
    end
    else
    begin
      ext_q <= ext_d;
    end
  end

  // The serial pins read as idle (low) whenever straps are in charge.
  // Framing and shifting happen downstream; this block only routes pins.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ser_q <= '0;
    end
    else if (ext_d)
    begin
      ser_q.serial_clock <= lvl_bit(straps_i.output_swing_level,
        1'b0);
      ser_q.serial_data_pin <= lvl_bit(straps_i.output_edge_select,
        1'b0);
      ser_q.serial_chip_select <= lvl_bit(
        straps_i.calibration_delay_select, 1'b0);
    end
    else
    begin
      ser_q <= '0;
    end
  end

  // Every access is answered one cycle after it is first seen.
  // A request left up after its answer is taken as a new access.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wait_q <= 1'b1;
    end
    else
    begin
      wait_q <= !((avs_read_i || avs_write_i) && wait_q);
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_q <= '0;
    end
    else if (rd_go)
    begin
      // Captured on the first cycle so it stands when waitrequest drops.
      rdata_q <= '0;
      for (int i = 0; i < CPMS_NUM_LOC; i++)
      begin
        if (hit[i])
        begin
          rdata_q[CPMS_LOC_W-1:0] <= loc_q[i];
        end
      end
      if (status_hit)
      begin
        rdata_q <= status_word(written_q, ext_q, set_q);
      end
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign ext_mode_o = ext_q;
  assign settings_o = set_q;
  assign serial_o = ser_q;

endmodule // cpms_mode_select

`default_nettype wire

// file: rtl/cpms_pkg.sv
package cpms_pkg;

  // Three-level strap pin as seen after the pad comparators.
  typedef enum logic [1:0] {
    CPMS_LVL_LOW,
    CPMS_LVL_HIGH,
    CPMS_LVL_FLOAT
  } cpms_lvl_e;

  typedef struct packed {
    cpms_lvl_e ctl_mode;
    cpms_lvl_e aux_mode;
    cpms_lvl_e output_swing_level;
    cpms_lvl_e output_edge_select;
    cpms_lvl_e calibration_delay_select;
    cpms_lvl_e input_full_scale_level;
  } cpms_straps_s;

  typedef struct packed {
    logic swing_normal;
    logic edge_pos;
    logic ddr;
    logic cal_long;
    logic fs_normal;
  } cpms_set_s;

  typedef struct packed {
    logic serial_clock;
    logic serial_data_pin;
    logic serial_chip_select;
  } cpms_ser_s;

  localparam int CPMS_ADDR_W = 8;
  localparam int CPMS_DATA_W = 32;
  localparam int CPMS_LOC_W = 8;
  localparam int CPMS_NUM_LOC = 9;
  localparam int CPMS_LOC_STEP = 4;

  localparam logic [CPMS_ADDR_W-1:0] CPMS_LOC_BASE = 8'h00;
  localparam logic [CPMS_ADDR_W-1:0] CPMS_STATUS_OFS = 8'h24;
  localparam logic [CPMS_LOC_W-1:0] CPMS_LOC_RST = 8'h13;

  // Field positions inside location 0.
  localparam int CPMS_F_SWING = 0;
  localparam int CPMS_F_EDGE = 1;
  localparam int CPMS_F_DDR = 2;
  localparam int CPMS_F_CAL = 3;
  localparam int CPMS_F_FS = 4;

  // Field positions inside the status word.
  localparam int CPMS_S_MASK = 0;
  localparam int CPMS_S_ALL = 9;
  localparam int CPMS_S_EXT = 10;
  localparam int CPMS_S_SET = 11;

  localparam cpms_set_s CPMS_SET_RST = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

endpackage

// file: tb/cpms_board.sv
`timescale 1ns/100ps
`default_nettype none
// Strap pads: two bits per pin, low 0, high 1, open 2.
module cpms_board
  import cpms_pkg::*;
(
  input wire logic [11:0] pins_i,
  output cpms_straps_s straps_o
);
  assign straps_o = cpms_straps_s'(pins_i);
endmodule // cpms_board
`default_nettype wire

// file: tb/cpms_mon_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module cpms_mon
  import cpms_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire cpms_straps_s straps_i,
  input wire logic ext_mode_o,
  input wire cpms_set_s settings_o,
  input wire cpms_ser_s serial_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Attempts wait one edge after reset so none judges reset values.
  logic live_q;
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      live_q <= 1'b0;
    end
    else
    begin
      live_q <= 1'b1;
    end
  end
  // Bit 1 of a strap marks open, bit 0 marks high.
  wire logic [11:0] q = straps_i;
  wire logic nx = live_q && q[11:10] == 2'h1;
  wire logic ex = live_q && q[11:10] != 2'h1 && q[9:8] != 2'h0 &&
    (q[11:10] == 2'h0 || q[1]);
  wire logic [2:0] sp = {q[6], q[4], q[2]};
  a_std_forced: assert property (
    nx |=> !ext_mode_o && serial_o == 3'h0) else $error("mode bad");
  a_ext_entry: assert property (
    ex |=> ext_mode_o) else $error("no ext");
  a_swing_strap: assert property (
    nx && !q[7] |=> settings_o.swing_normal == $past(q[6]))
    else $error("swing bad");
  a_edge_strap: assert property (
    nx && !q[5] |=> settings_o.edge_pos == $past(q[4]) && !settings_o.ddr)
    else $error("edge bad");
  a_ddr_open: assert property (
    nx && q[5] |=> settings_o.ddr) else $error("ddr bad");
  a_cal_strap: assert property (
    nx && !q[3] |=> settings_o.cal_long == $past(q[2]))
    else $error("delay bad");
  a_scale_strap: assert property (
    nx && !q[1] |=> settings_o.fs_normal == $past(q[0]))
    else $error("scale bad");
  a_serial_pins: assert property (
    ex |=> serial_o == $past(sp)) else $error("serial bad");
endmodule // cpms_mon
bind cpms_mode_select cpms_mon u_mon (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .straps_i(straps_i), .ext_mode_o(ext_mode_o),
  .settings_o(settings_o), .serial_o(serial_o));
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import cpms_pkg::*;
;
  logic mclk_i = 1'b0, rstn_i = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [11:0] pins = 12'h555;
  logic [3:0] be = 4'hf;
  wire logic [31:0] rdo;
  wire logic wt, ext;
  wire cpms_set_s set;
  wire cpms_ser_s ser;
  wire cpms_straps_s st;
  int n_fail = 0, checked = 0, i, k;
  always #50 mclk_i = ~mclk_i;
  cpms_board board (.pins_i(pins), .straps_o(st));
  cpms_mode_select dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .straps_i(st),
    .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdo),
    .avs_waitrequest_o(wt), .ext_mode_o(ext), .settings_o(set),
    .serial_o(ser));
  task results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask
  // Waitrequest is sampled at the edge, so the old value is the answer.
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    k = 0;
    do
    begin
      @(posedge mclk_i);
      k++;
    end while (wt !== 1'b0 && k < 20);
    rdat = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wt !== 1'b0)
    begin
      chk(wt, 32'h0);
      results;
    end
  endtask
  task pin(input logic [11:0] p);
    pins <= p;
    repeat (2) @(posedge mclk_i);
  endtask
  initial
  begin
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      pin({4'h5, {4{i[1:0]}}});
      chk(set, {i[0], i[0], 1'b0, i[0], i[0]});
      chk({ext, ser}, 4'h0);
    end
    pin(12'h520);
    chk(set, 5'h0c);
    $display("strap test done");
    pin(12'h245);
    chk({ext, ser, set}, 9'h1b9);
    acc(1'b1, 8'h00, 32'h0c);
    repeat (2) @(posedge mclk_i);
    chk(set, 5'h06);
    acc(1'b0, CPMS_STATUS_OFS, 32'h0);
    chk(rdat, 32'h3401);
    for (i = 1; i < 9; i++)
      acc(1'b1, 8'(4 * i), i);
    acc(1'b1, CPMS_STATUS_OFS, 32'h0);
    acc(1'b0, CPMS_STATUS_OFS, 32'h0);
    chk(rdat, 32'h37ff);
    be <= 4'h0;
    acc(1'b1, 8'h20, 32'h55);
    be <= 4'hf;
    acc(1'b0, 8'h20, 32'h0);
    chk(rdat, 32'h8);
    acc(1'b1, 8'h40, 32'hff);
    acc(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h0);
    $display("register test done");
    pin(12'h902);
    chk(ext, 1'b1);
    pin(12'h802);
    chk(ext, 1'b0);
    $display("mode test done");
    results;
  end
endmodule // testbench
`default_nettype wire
